// *** common/ecr_defs.svh ***
// Constants for the error class routing block: register offsets, field layout, reset values.
// Assumes a 32-bit AHB-Lite register port decoding the low eight address bits.
`ifndef ECR_DEFS_SVH
`define ECR_DEFS_SVH

`define ECR_OFS_CTRL 8'h00
`define ECR_OFS_MARK 8'h04
`define ECR_OFS_STCHG 8'h08
`define ECR_OFS_URGENT 8'h0c
`define ECR_OFS_STATUS 8'h10

`define ECR_CTRL_RESET 32'h0000_0001
`define ECR_CTRL_WEAK_BIT 0
`define ECR_MARK_RESET 32'h0000_0000
`define ECR_FIELD_W 8
`define ECR_LOG_VALID_BIT 7
`define ECR_LOG_ENDM_LSB 5
`define ECR_CAUSE_W 5
`define ECR_LOG_CLEAR 8'h00
`define ECR_STAT_FATAL_BIT 0
`define ECR_STAT_PWDR_LSB 4
`define ECR_STAT_PADE_LSB 8
`define ECR_STAT_PAUGE_LSB 12
`define ECR_HTRANS_ACTIVE_BIT 1
`define ECR_HRESP_OKAY 1'b0
`define ECR_CORE0_MASK 4'h3
`define ECR_CORE1_MASK 4'hc
`define ECR_ALL_MASK 4'hf

`endif

// *** common/ecr_pkg.sv ***
// Types shared by the error class routing block.
// Assumes ecr_defs.svh supplies the numeric constants.
package ecr_pkg;
	// Detected error sources as presented by the detectors
	typedef enum logic [4:0] {
		ERR_FATAL,
		ERR_EE_TRAP_ADDR_UE,
		ERR_OTHER_STATE_ERROR,
		ERR_EE_SIR_MAX,
		ERR_EE_TRAP_MAX,
		ERR_EE_WDT_MAX,
		ERR_SECOND_WDT_TIMEOUT,
		ERR_IUG_CTRL_REG,
		ERR_IUG_FIRST_WDT,
		ERR_IUG_EXEC_UNIT,
		ERR_IUG_REG_PARITY,
		ERR_IFETCH_UE,
		ERR_DFETCH_UE,
		ERR_AUTO_UGE,
		ERR_RAW_UE_L1,
		ERR_RAW_UE_L2,
		ERR_RESTRAIN_OTHER
	} ecr_err_t;
	// Severity classes
	typedef enum logic [1:0] {CLS_FATAL, CLS_STATE, CLS_URGENT, CLS_RESTRAIN} ecr_class_t;
	// Urgent error kinds
	typedef enum logic [2:0] {UGE_NONE, UGE_INSTR, UGE_IFETCH, UGE_DFETCH, UGE_AUTO} ecr_uge_t;
endpackage

// *** rtl/ecr_sync2.sv ***
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the input changes slowly compared with the clock.
`timescale 1ns/100ps
module ecr_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else if (ce_in) begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end
	assign q_out = sync_q;
endmodule

// *** rtl/ecr_thread_sel.sv ***
// Picks the lowest-numbered set bit of a thread mask.
// Assumes bit 0 is core0 thread0 and bits rise with core then thread.
`timescale 1ns/100ps
module ecr_thread_sel #(
	parameter int N = 4,
	parameter int IW = 2
) (
	input wire logic [N-1:0] mask_in,
	output logic found_out,
	output logic [IW-1:0] idx_out
);
	logic [N:0] below;
	logic [N-1:0] first;

	// Prefix OR: a thread wins only if no lower thread is eligible
	assign below[0] = 1'b0;
	for (genvar i = 0; i < N; i++) begin : g_pri
		assign below[i+1] = below[i] | mask_in[i];
		assign first[i] = mask_in[i] & ~below[i];
	end

	// Encode the single winner
	always_comb begin
		idx_out = '0;
		for (int i = 0; i < N; i++) begin
			if (first[i]) begin
				idx_out = IW'(i);
			end
		end
	end
	assign found_out = below[N];
endmodule

// *** rtl/ecr_top.sv ***
// Error classification and routing for a module of two cores with two threads each.
// Assumes one error report per cycle from same-clock detectors, an AHB-Lite master on the
// register port, and a system controller whose fatal-reset pin is asynchronous.
`timescale 1ns/100ps
`include "ecr_defs.svh"
module ecr_top #(
	parameter int NT = 4,
	parameter int TW = 2
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Error reports from detectors
	input wire logic err_valid_in,
	input wire ecr_pkg::ecr_err_t err_code_in,
	input wire logic [TW-1:0] err_thread_in,
	input wire logic [1:0] err_end_method_in,
	input wire logic weak_possible_in,
	// Thread state
	input wire logic [NT-1:0] suspended_in,
	input wire logic [NT-1:0] degraded_in,
	input wire logic [NT-1:0] uge_handler_in,
	// System controller pin
	input wire logic sysctl_fatal_reset_in,
	// Classification
	output logic class_valid_out,
	output ecr_pkg::ecr_class_t class_out,
	// Fatal reporting
	output logic fatal_report_out,
	output logic [NT-1:0] por_req_out,
	// Per-thread actions
	output logic [NT-1:0] wdr_req_out,
	output logic [NT-1:0] stchg_log_out,
	output logic [NT-1:0] urgent_log_out,
	output logic [NT-1:0] async_error_trap_out,
	output logic [NT-1:0] ifetch_trap_out,
	output logic [NT-1:0] dfetch_trap_out,
	output logic [NT-1:0] weak_complete_out,
	// Error marking
	output logic mark_valid_out,
	output logic [`ECR_FIELD_W-1:0] mark_id_out
);
	import ecr_pkg::*;

	localparam int FW = `ECR_FIELD_W;

	// Registers and state
	logic [31:0] ctrl_q;
	logic [31:0] mark_q;
	logic [FW-1:0] stchg_q [NT];
	logic [FW-1:0] urg_q [NT];
	logic fatal_q;
	logic cls_valid_q;
	ecr_class_t cls_q;
	logic mark_valid_q;
	logic [FW-1:0] mark_id_q;
	logic [NT-1:0] pend_wdr_q;
	logic [NT-1:0] pend_ade_q;
	logic [NT-1:0] pend_auge_q;
	logic [NT-1:0] pend_if_q;
	logic [NT-1:0] pend_df_q;
	logic [`ECR_CAUSE_W-1:0] st_cause_q [NT];
	logic [`ECR_CAUSE_W-1:0] ug_cause_q [NT];
	logic [1:0] ug_endm_q [NT];
	logic [NT-1:0] por_q;
	logic [NT-1:0] wdr_q;
	logic [NT-1:0] stlog_q;
	logic [NT-1:0] uglog_q;
	logic [NT-1:0] ade_q;
	logic [NT-1:0] if_q;
	logic [NT-1:0] df_q;
	logic [NT-1:0] weak_q;

	// Bus state
	logic bus_wr_q;
	logic [7:0] bus_addr_q;
	logic [31:0] rdata_q;

	// Classification results
	ecr_class_t cls_c;
	ecr_uge_t uge_c;
	logic [NT-1:0] scope_c;
	logic mark_c;
	logic [NT-1:0] tied_c;
	logic weak_en;
	logic sys_reset_s;
	logic sel_found;
	logic [TW-1:0] sel_idx;
	logic [NT-1:0] thread_bit;
	logic [NT-1:0] core_bits;
	logic fire;
	logic addr_ph;
	logic [31:0] status_c;
	logic [31:0] stchg_rd;
	logic [31:0] urg_rd;

	assign weak_en = ctrl_q[`ECR_CTRL_WEAK_BIT];
	assign fire = err_valid_in & ce_in;
	assign thread_bit = NT'(1) << err_thread_in;
	assign core_bits = err_thread_in[TW-1] ? `ECR_CORE1_MASK : `ECR_CORE0_MASK;

	// Fatal-reset pin comes from the system controller's own timing
	ecr_sync2 #(.W(1)) u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.d_in(sysctl_fatal_reset_in),
		.q_out(sys_reset_s)
	);

	// Sort each error into a class, a thread scope and an urgent kind
	always_comb begin
		cls_c = CLS_RESTRAIN;
		uge_c = UGE_NONE;
		scope_c = '0;
		mark_c = 1'b0;
		tied_c = '0;
		case (err_code_in)
			ERR_FATAL: begin
				cls_c = CLS_FATAL;
				scope_c = `ECR_ALL_MASK;
			end
			ERR_EE_TRAP_ADDR_UE, ERR_OTHER_STATE_ERROR: begin
				cls_c = CLS_STATE;
				scope_c = core_bits;
			end
			ERR_EE_SIR_MAX, ERR_EE_TRAP_MAX, ERR_EE_WDT_MAX, ERR_SECOND_WDT_TIMEOUT: begin
				cls_c = CLS_STATE;
				scope_c = thread_bit;
			end
			ERR_IUG_CTRL_REG, ERR_IUG_FIRST_WDT, ERR_IUG_EXEC_UNIT: begin
				cls_c = CLS_URGENT;
				uge_c = UGE_INSTR;
				scope_c = core_bits;
			end
			ERR_IUG_REG_PARITY: begin
				cls_c = CLS_URGENT;
				uge_c = UGE_INSTR;
				scope_c = thread_bit;
			end
			ERR_IFETCH_UE: begin
				cls_c = CLS_URGENT;
				uge_c = UGE_IFETCH;
				scope_c = thread_bit;
			end
			ERR_DFETCH_UE: begin
				cls_c = CLS_URGENT;
				uge_c = UGE_DFETCH;
				scope_c = thread_bit;
			end
			ERR_AUTO_UGE: begin
				cls_c = CLS_URGENT;
				uge_c = UGE_AUTO;
				scope_c = core_bits;
			end
			ERR_RAW_UE_L1: begin
				mark_c = 1'b1;
				tied_c = core_bits & ~degraded_in;
			end
			ERR_RAW_UE_L2: begin
				mark_c = 1'b1;
				tied_c = `ECR_ALL_MASK & ~degraded_in;
			end
			default: begin
				cls_c = CLS_RESTRAIN;
			end
		endcase
	end

	// Lowest eligible thread supplies the marking id
	ecr_thread_sel #(.N(NT), .IW(TW)) u_sel (
		.mask_in(tied_c),
		.found_out(sel_found),
		.idx_out(sel_idx)
	);

	// Class report and error marking, one cycle after the error
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cls_valid_q <= 1'b0;
			cls_q <= CLS_RESTRAIN;
			mark_valid_q <= 1'b0;
			mark_id_q <= '0;
		end else if (ce_in) begin
			cls_valid_q <= err_valid_in;
			if (err_valid_in) begin
				cls_q <= cls_c;
			end
			mark_valid_q <= err_valid_in & mark_c & sel_found;
			if (err_valid_in & mark_c & sel_found) begin
				mark_id_q <= mark_q[sel_idx*FW +: FW];
			end
		end
	end

	// Fatal state holds until the controller's fatal reset arrives; a new fatal wins
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fatal_q <= 1'b0;
		end else if (ce_in) begin
			if (err_valid_in && cls_c == CLS_FATAL) begin
				fatal_q <= 1'b1;
			end else if (sys_reset_s) begin
				fatal_q <= 1'b0;
			end
		end
	end

	// Per-thread deferral, delivery and logging
	for (genvar t = 0; t < NT; t++) begin : g_thr
		logic hit;
		logic run;
		logic fat;
		logic st_set;
		logic ug_set;
		logic aug_set;
		logic weak_done;
		logic instr_obs;
		logic dlv_wdr;
		logic dlv_ade;
		logic dlv_aug;
		logic dlv_if;
		logic dlv_df;
		logic st_clr;
		logic ug_clr;

		assign hit = fire & scope_c[t];
		assign run = ~suspended_in[t];
		assign fat = hit & (cls_c == CLS_FATAL);
		assign st_set = hit & (cls_c == CLS_STATE);
		assign instr_obs = (uge_c == UGE_INSTR) | (uge_c == UGE_IFETCH) | (uge_c == UGE_DFETCH);
		// Weak detect lets a damaged instruction finish where the pipe can do so
		assign weak_done = hit & instr_obs & weak_en & weak_possible_in;
		assign ug_set = hit & instr_obs & ~weak_done;
		assign aug_set = hit & (uge_c == UGE_AUTO) & ~weak_en;
		assign dlv_wdr = pend_wdr_q[t] & run;
		assign dlv_ade = pend_ade_q[t] & run;
		// Global interrupt enable is not consulted here
		assign dlv_aug = pend_auge_q[t] & run & ~uge_handler_in[t] & ~weak_en;
		assign dlv_if = pend_if_q[t] & run;
		assign dlv_df = pend_df_q[t] & run;
		assign st_clr = bus_wr_q & (bus_addr_q == `ECR_OFS_STCHG) & hwdata_in[t*FW+`ECR_LOG_VALID_BIT];
		assign ug_clr = bus_wr_q & (bus_addr_q == `ECR_OFS_URGENT) & hwdata_in[t*FW+`ECR_LOG_VALID_BIT];

		// Pending work and its cause; fatal bypasses suspend and the queue
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				pend_wdr_q[t] <= 1'b0;
				pend_ade_q[t] <= 1'b0;
				pend_auge_q[t] <= 1'b0;
				pend_if_q[t] <= 1'b0;
				pend_df_q[t] <= 1'b0;
				st_cause_q[t] <= '0;
				ug_cause_q[t] <= '0;
				ug_endm_q[t] <= '0;
			end else if (ce_in) begin
				if (fat) begin
					pend_wdr_q[t] <= 1'b0;
				end else if (st_set) begin
					pend_wdr_q[t] <= 1'b1;
				end else if (dlv_wdr) begin
					pend_wdr_q[t] <= 1'b0;
				end
				if (st_set) begin
					st_cause_q[t] <= `ECR_CAUSE_W'(err_code_in);
				end
				if (ug_set & (uge_c == UGE_INSTR)) begin
					pend_ade_q[t] <= 1'b1;
				end else if (dlv_ade) begin
					pend_ade_q[t] <= 1'b0;
				end
				if (weak_en) begin
					pend_auge_q[t] <= 1'b0;
				end else if (aug_set) begin
					pend_auge_q[t] <= 1'b1;
				end else if (dlv_aug) begin
					pend_auge_q[t] <= 1'b0;
				end
				if (ug_set & (uge_c == UGE_IFETCH)) begin
					pend_if_q[t] <= 1'b1;
				end else if (dlv_if) begin
					pend_if_q[t] <= 1'b0;
				end
				if (ug_set & (uge_c == UGE_DFETCH)) begin
					pend_df_q[t] <= 1'b1;
				end else if (dlv_df) begin
					pend_df_q[t] <= 1'b0;
				end
				if (ug_set | aug_set) begin
					ug_cause_q[t] <= `ECR_CAUSE_W'(err_code_in);
					ug_endm_q[t] <= err_end_method_in;
				end
			end
		end

		// One-cycle action pulses to the thread
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				por_q[t] <= 1'b0;
				wdr_q[t] <= 1'b0;
				stlog_q[t] <= 1'b0;
				uglog_q[t] <= 1'b0;
				ade_q[t] <= 1'b0;
				if_q[t] <= 1'b0;
				df_q[t] <= 1'b0;
				weak_q[t] <= 1'b0;
			end else if (ce_in) begin
				por_q[t] <= fat;
				wdr_q[t] <= dlv_wdr & ~fat;
				stlog_q[t] <= fat | (dlv_wdr & ~fat);
				uglog_q[t] <= dlv_ade | dlv_aug;
				ade_q[t] <= dlv_ade | dlv_aug;
				if_q[t] <= dlv_if;
				df_q[t] <= dlv_df;
				weak_q[t] <= weak_done;
			end
		end

		// Software-visible logs; a new entry wins over a clear in the same cycle
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				stchg_q[t] <= `ECR_LOG_CLEAR;
				urg_q[t] <= `ECR_LOG_CLEAR;
			end else if (ce_in) begin
				if (fat) begin
					stchg_q[t] <= {1'b1, 2'b00, `ECR_CAUSE_W'(err_code_in)};
				end else if (dlv_wdr) begin
					stchg_q[t] <= {1'b1, 2'b00, st_cause_q[t]};
				end else if (st_clr) begin
					stchg_q[t] <= `ECR_LOG_CLEAR;
				end
				if (dlv_ade | dlv_aug) begin
					urg_q[t] <= {1'b1, ug_endm_q[t], ug_cause_q[t]};
				end else if (ug_clr) begin
					urg_q[t] <= `ECR_LOG_CLEAR;
				end
			end
		end

		assign stchg_rd[t*FW +: FW] = stchg_q[t];
		assign urg_rd[t*FW +: FW] = urg_q[t];
	end

	// Status word: fatal state and pending reset, async trap and auto urgent work per thread
	always_comb begin
		status_c = '0;
		status_c[`ECR_STAT_FATAL_BIT] = fatal_q;
		status_c[`ECR_STAT_PWDR_LSB +: NT] = pend_wdr_q;
		status_c[`ECR_STAT_PADE_LSB +: NT] = pend_ade_q;
		status_c[`ECR_STAT_PAUGE_LSB +: NT] = pend_auge_q;
	end

	assign addr_ph = hsel_in & htrans_in[`ECR_HTRANS_ACTIVE_BIT] & hready_in;

	// Address phase capture; read data is fetched here so it leaves a flop
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bus_wr_q <= 1'b0;
			bus_addr_q <= '0;
			rdata_q <= '0;
		end else if (ce_in) begin
			bus_wr_q <= addr_ph & hwrite_in;
			if (addr_ph) begin
				bus_addr_q <= haddr_in[7:0];
			end
			if (addr_ph & ~hwrite_in) begin
				case (haddr_in[7:0])
					`ECR_OFS_CTRL: rdata_q <= ctrl_q;
					`ECR_OFS_MARK: rdata_q <= mark_q;
					`ECR_OFS_STCHG: rdata_q <= stchg_rd;
					`ECR_OFS_URGENT: rdata_q <= urg_rd;
					`ECR_OFS_STATUS: rdata_q <= status_c;
					default: rdata_q <= '0;
				endcase
			end
		end
	end

	// Writable control and marking id registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_q <= `ECR_CTRL_RESET;
			mark_q <= `ECR_MARK_RESET;
		end else if (ce_in && bus_wr_q) begin
			if (bus_addr_q == `ECR_OFS_CTRL) begin
				ctrl_q <= {31'h0, hwdata_in[`ECR_CTRL_WEAK_BIT]};
			end
			if (bus_addr_q == `ECR_OFS_MARK) begin
				mark_q <= hwdata_in;
			end
		end
	end

	assign hrdata_out = rdata_q;
	assign hreadyout_out = 1'b1;
	assign hresp_out = `ECR_HRESP_OKAY;
	assign class_valid_out = cls_valid_q;
	assign class_out = cls_q;
	assign fatal_report_out = fatal_q;
	assign por_req_out = por_q;
	assign wdr_req_out = wdr_q;
	assign stchg_log_out = stlog_q;
	assign urgent_log_out = uglog_q;
	assign async_error_trap_out = ade_q;
	assign ifetch_trap_out = if_q;
	assign dfetch_trap_out = df_q;
	assign weak_complete_out = weak_q;
	assign mark_valid_out = mark_valid_q;
	assign mark_id_out = mark_id_q;
endmodule

// *** test/ecr_sysctl_model.sv ***
// System controller model: stops the system after a fatal report, then holds the fatal reset.
// Assumes the same clock and reset as the block; reset is released once the report clears.
`timescale 1ns/100ps
module ecr_sysctl_model #(
	parameter int STOP_CYC = 20
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic fatal_report_in,
	output logic fatal_reset_out
);
	logic [7:0] stop_q;
	// Count the stop phase, then issue the fatal reset until the report clears
	always_ff @(posedge clk_in) begin
		if (rst_in || !fatal_report_in) begin
			stop_q <= 8'h00;
			fatal_reset_out <= 1'b0;
		end else if (stop_q == 8'(STOP_CYC)) begin
			fatal_reset_out <= 1'b1;
		end else begin
			stop_q <= stop_q + 8'h01;
		end
	end
endmodule

// *** test/ecr_top_checker.sv ***
// Checker for ecr_top: classification latency and per-thread action masks at the ports.
// Assumes ce_in is high whenever an error is reported.
`timescale 1ns/100ps
module ecr_top_checker
	import ecr_pkg::*;
#(
	parameter int NT = 4,
	parameter int TW = 2
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic err_valid_in,
	input wire ecr_pkg::ecr_err_t err_code_in,
	input wire logic [TW-1:0] err_thread_in,
	input wire logic [NT-1:0] suspended_in,
	input wire logic sysctl_fatal_reset_in,
	input wire logic class_valid_out,
	input wire ecr_pkg::ecr_class_t class_out,
	input wire logic fatal_report_out,
	input wire logic [NT-1:0] por_req_out,
	input wire logic [NT-1:0] wdr_req_out,
	input wire logic [NT-1:0] stchg_log_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Error reports by kind
	sequence sync_ee_s;
		err_valid_in && ce_in && err_code_in inside {ERR_EE_SIR_MAX, ERR_EE_TRAP_MAX, ERR_EE_WDT_MAX, ERR_SECOND_WDT_TIMEOUT};
	endsequence
	sequence async_ee_s;
		err_valid_in && ce_in && err_code_in inside {ERR_EE_TRAP_ADDR_UE, ERR_OTHER_STATE_ERROR};
	endsequence
	sequence quiet_s;
		suspended_in == 4'h0 && !err_valid_in;
	endsequence
	class_lat_a: assert property (err_valid_in && ce_in |=> class_valid_out)
		else $error("class result missing");
	fatal_rep_a: assert property (err_valid_in && ce_in && err_code_in == ERR_FATAL |=>
		fatal_report_out && por_req_out == 4'hf && stchg_log_out == 4'hf) else $error("fatal fan-out wrong");
	por_cause_a: assert property (por_req_out != 4'h0 |->
		$past(err_valid_in) && $past(err_code_in) == ERR_FATAL) else $error("power-on request without fatal");
	state_cls_a: assert property (sync_ee_s or async_ee_s |=> class_out == CLS_STATE)
		else $error("state class wrong");
	urgent_cls_a: assert property (err_valid_in && ce_in && err_code_in inside {ERR_IUG_CTRL_REG,
		ERR_IUG_FIRST_WDT, ERR_IUG_EXEC_UNIT, ERR_IUG_REG_PARITY, ERR_IFETCH_UE, ERR_DFETCH_UE, ERR_AUTO_UGE}
		|=> class_out == CLS_URGENT) else $error("urgent class wrong");
	sync_wdr_a: assert property (sync_ee_s ##0 suspended_in == 4'h0 ##1 quiet_s |=>
		wdr_req_out == (4'h1 << $past(err_thread_in, 2))) else $error("sync reset mask wrong");
	async_wdr_a: assert property (async_ee_s ##0 suspended_in == 4'h0 ##1 quiet_s |=>
		wdr_req_out == (($past(err_thread_in, 2) >= 2'h2) ? 4'hc : 4'h3)) else $error("core reset mask wrong");
	defer_wdr_a: assert property (sync_ee_s ##0 suspended_in == 4'hf ##1 suspended_in == 4'hf |=>
		wdr_req_out == 4'h0) else $error("reset reached suspended thread");
	fatal_hold_a: assert property (fatal_report_out && !sysctl_fatal_reset_in && !$past(sysctl_fatal_reset_in) &&
		!$past(sysctl_fatal_reset_in, 2) && !$past(sysctl_fatal_reset_in, 3) |=> fatal_report_out)
		else $error("fatal report dropped early");
endmodule
bind ecr_top ecr_top_checker #(.NT(NT), .TW(TW)) chk_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
	.err_valid_in(err_valid_in), .err_code_in(err_code_in), .err_thread_in(err_thread_in),
	.suspended_in(suspended_in), .sysctl_fatal_reset_in(sysctl_fatal_reset_in), .class_valid_out(class_valid_out),
	.class_out(class_out), .fatal_report_out(fatal_report_out), .por_req_out(por_req_out),
	.wdr_req_out(wdr_req_out), .stchg_log_out(stchg_log_out));

// *** test/ecr_top_tb.sv ***
// Self-checking bench for ecr_top: errors of every class, register access, fatal reset loop.
// Assumes ecr_sysctl_model answers fatal reports; hready is the slave's own hreadyout.
`timescale 1ns/100ps
`include "ecr_defs.svh"
module ecr_top_tb;
	import ecr_pkg::*;
	logic clk_in, rst_in, ce_in, hsel_in, hwrite_in, hreadyout_out, hresp_out, err_valid_in, weak_possible_in;
	logic [31:0] haddr_in, hwdata_in, hrdata_out;
	logic [1:0] htrans_in, err_thread_in, err_end_method_in;
	logic [2:0] hsize_in;
	logic [3:0] suspended_in, degraded_in, uge_handler_in, por_req_out, wdr_req_out, stchg_log_out;
	logic [3:0] urgent_log_out, async_error_trap_out, ifetch_trap_out, dfetch_trap_out, weak_complete_out;
	logic [3:0] a_wdr, a_stl, a_ugl, a_ade, a_if, a_df, a_wc, a_por;
	logic sysctl_fatal_reset_in, class_valid_out, fatal_report_out, mark_valid_out, a_mk;
	logic [7:0] mark_id_out, mk;
	ecr_err_t err_code_in;
	ecr_class_t class_out, cls;
	int n_fail, n_tests;
	ecr_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
		.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
		.hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
		.err_valid_in(err_valid_in), .err_code_in(err_code_in), .err_thread_in(err_thread_in),
		.err_end_method_in(err_end_method_in), .weak_possible_in(weak_possible_in), .suspended_in(suspended_in),
		.degraded_in(degraded_in), .uge_handler_in(uge_handler_in), .sysctl_fatal_reset_in(sysctl_fatal_reset_in),
		.class_valid_out(class_valid_out), .class_out(class_out), .fatal_report_out(fatal_report_out),
		.por_req_out(por_req_out), .wdr_req_out(wdr_req_out), .stchg_log_out(stchg_log_out),
		.urgent_log_out(urgent_log_out), .async_error_trap_out(async_error_trap_out),
		.ifetch_trap_out(ifetch_trap_out), .dfetch_trap_out(dfetch_trap_out),
		.weak_complete_out(weak_complete_out), .mark_valid_out(mark_valid_out), .mark_id_out(mark_id_out));
	ecr_sysctl_model sc_u (.clk_in(clk_in), .rst_in(rst_in), .fatal_report_in(fatal_report_out),
		.fatal_reset_out(sysctl_fatal_reset_in));
	// Clock, 4 ns period
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	task automatic report_and_stop();
		if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One AHB-Lite single word transfer; waits on hready in both phases
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_in);
		hsel_in <= 1'b1; htrans_in <= 2'h2; haddr_in <= a; hwrite_in <= wr; hsize_in <= 3'h2;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		hsel_in <= 1'b0; htrans_in <= 2'h0; hwdata_in <= wd;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		rd = hrdata_out;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r, e);
		chk(32'(hresp_out), 32'(`ECR_HRESP_OKAY));
	endtask
	// Gather five cycles of per-thread pulses
	task automatic obs();
		{a_wdr, a_stl, a_ugl, a_ade, a_if, a_df, a_wc, a_por, a_mk} = '0;
		repeat (5) begin
			#1;
			if (class_valid_out === 1'b1) cls = class_out;
			if (mark_valid_out === 1'b1) mk = mark_id_out;
			a_wdr |= wdr_req_out; a_stl |= stchg_log_out; a_ugl |= urgent_log_out; a_ade |= async_error_trap_out;
			a_if |= ifetch_trap_out; a_df |= dfetch_trap_out; a_wc |= weak_complete_out; a_por |= por_req_out;
			a_mk |= mark_valid_out;
			@(posedge clk_in);
		end
	endtask
	task automatic fire(input ecr_err_t c, input logic [1:0] t);
		@(posedge clk_in);
		err_valid_in <= 1'b1; err_code_in <= c; err_thread_in <= t;
		@(posedge clk_in);
		err_valid_in <= 1'b0;
		obs();
	endtask
	task automatic t_state();
		ecr_err_t sc[3] = '{ERR_EE_TRAP_MAX, ERR_EE_WDT_MAX, ERR_SECOND_WDT_TIMEOUT};
		rdc(`ECR_OFS_CTRL, 32'h1);
		rdc(`ECR_OFS_MARK, 32'h0);
		rdc(32'h14, 32'h0);
		fire(ERR_EE_SIR_MAX, 2'h1);
		chk(32'(cls), 32'(CLS_STATE));
		chk(32'(a_wdr), 32'h2);
		chk(32'(a_stl), 32'h2);
		rdc(`ECR_OFS_STCHG, {16'h0, 1'b1, 2'h0, 5'(ERR_EE_SIR_MAX), 8'h0});
		wr(`ECR_OFS_STCHG, 32'h8000);
		rdc(`ECR_OFS_STCHG, 32'h0);
		foreach (sc[i]) begin
			fire(sc[i], 2'h3);
			chk(32'(a_wdr), 32'h8);
		end
		fire(ERR_EE_TRAP_ADDR_UE, 2'h2);
		chk(32'(a_wdr), 32'hc);
		fire(ERR_OTHER_STATE_ERROR, 2'h0);
		chk(32'(a_stl), 32'h3);
	endtask
	task automatic t_defer();
		suspended_in <= 4'hf;
		fire(ERR_EE_SIR_MAX, 2'h0);
		chk(32'(a_wdr), 32'h0);
		rdc(`ECR_OFS_STATUS, 32'h10);
		suspended_in <= 4'h0;
		obs();
		chk(32'(a_wdr), 32'h1);
	endtask
	task automatic t_urgent();
		ecr_err_t cs[7] = '{ERR_IUG_REG_PARITY, ERR_IUG_CTRL_REG, ERR_IUG_EXEC_UNIT, ERR_IUG_FIRST_WDT,
			ERR_AUTO_UGE, ERR_IFETCH_UE, ERR_DFETCH_UE};
		logic [1:0] th[7] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2};
		logic [3:0] ea[7] = '{4'h8, 4'h3, 4'hc, 4'h3, 4'hc, 4'h0, 4'h0};
		wr(`ECR_OFS_CTRL, 32'h0);
		weak_possible_in <= 1'b1;
		foreach (cs[i]) begin
			fire(cs[i], th[i]);
			chk(32'(cls), 32'(CLS_URGENT));
			chk(32'(a_ade), 32'(ea[i]));
			if (ea[i] != 4'h0) chk(32'(a_ugl), 32'(ea[i]));
		end
		chk(32'(a_df), 32'h4);
		fire(ERR_IFETCH_UE, 2'h1);
		chk(32'(a_if), 32'h2);
	endtask
	task automatic t_handler();
		logic [7:0] e;
		e = {1'b1, 2'h2, 5'(ERR_AUTO_UGE)};
		wr(`ECR_OFS_URGENT, 32'h8080_8080);
		uge_handler_in <= 4'hc;
		err_end_method_in <= 2'h2;
		fire(ERR_AUTO_UGE, 2'h2);
		chk(32'(a_ade), 32'h0);
		uge_handler_in <= 4'h0;
		obs();
		chk(32'(a_ade), 32'hc);
		rdc(`ECR_OFS_URGENT, {e, e, 16'h0});
		err_end_method_in <= 2'h0;
	endtask
	task automatic t_weak();
		wr(`ECR_OFS_CTRL, 32'h1);
		fire(ERR_IUG_EXEC_UNIT, 2'h0);
		chk(32'(a_ade), 32'h0);
		chk(32'(a_wc != 4'h0), 32'h1);
		weak_possible_in <= 1'b0;
		fire(ERR_DFETCH_UE, 2'h1);
		chk(32'(a_df), 32'h2);
		fire(ERR_AUTO_UGE, 2'h0);
		chk(32'(a_ade), 32'h0);
	endtask
	task automatic t_mark();
		wr(`ECR_OFS_MARK, 32'h4433_2211);
		degraded_in <= 4'h4;
		fire(ERR_RAW_UE_L1, 2'h2);
		chk({24'h0, mk}, 32'h44);
		chk(32'(cls), 32'(CLS_RESTRAIN));
		degraded_in <= 4'h1;
		fire(ERR_RAW_UE_L2, 2'h3);
		chk({24'h0, mk}, 32'h22);
		degraded_in <= 4'hf;
		fire(ERR_RAW_UE_L2, 2'h0);
		chk(32'(a_mk), 32'h0);
		degraded_in <= 4'h0;
	endtask
	// Clock enable low: a report in a frozen cycle is not taken
	task automatic t_freeze();
		ce_in <= 1'b0;
		fire(ERR_EE_SIR_MAX, 2'h0);
		chk(32'(a_wdr | a_stl), 32'h0);
		ce_in <= 1'b1;
	endtask
	task automatic t_fatal();
		int k;
		suspended_in <= 4'h5;
		fire(ERR_FATAL, 2'h1);
		chk(32'(cls), 32'(CLS_FATAL));
		chk(32'(a_por), 32'hf);
		chk(32'(a_stl), 32'hf);
		chk(32'(fatal_report_out), 32'h1);
		k = 0;
		while (fatal_report_out !== 1'b0 && k < 200) begin
			@(posedge clk_in);
			k++;
		end
		chk(32'(fatal_report_out), 32'h0);
		suspended_in <= 4'h0;
	endtask
	// Main sequence
	initial begin
		{rst_in, ce_in} = 2'b11;
		{hsel_in, hwrite_in, err_valid_in, weak_possible_in} = '0;
		{haddr_in, hwdata_in, htrans_in, hsize_in, err_thread_in, err_end_method_in} = '0;
		{suspended_in, degraded_in, uge_handler_in} = '0;
		err_code_in = ERR_FATAL;
		n_fail = 0;
		n_tests = 0;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		t_state();
		t_defer();
		t_urgent();
		t_handler();
		t_weak();
		t_mark();
		t_freeze();
		t_fatal();
		report_and_stop();
	end
	// Watchdog against a hung handshake
	initial begin
		#80000;
		n_fail++;
		report_and_stop();
	end
endmodule
